// File: cpr_pkg.sv
package cpr_pkg;

  // ----------------------------------------------------------------
  // machine cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam int unsigned OSC_PER_STATE    = 2;
  localparam int unsigned OSC_PER_CYCLE    = STATES_PER_CYCLE * OSC_PER_STATE;
  localparam logic [3:0]  PHASE_LAST       = 4'hb;
  localparam logic [3:0]  PHASE_S1P1       = 4'h0;
  localparam logic [3:0]  PHASE_S4P1       = 4'h6;
  localparam logic [3:0]  PHASE_STATE5_PHASE2 = 4'h9;
  localparam logic [1:0]  RESET_HOLD_CYC   = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  SP_RESET   = 8'h07;
  localparam logic [7:0]  PORT_RESET = 8'hff;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [15:0] WDT_LIMIT_DEFAULT = 16'hffff;

  // ----------------------------------------------------------------
  // register map (axi4-lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CHIP_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_WDT_CONTROL   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS        = 8'h10;
  localparam logic [7:0] ADDR_EVT_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_EVT_MASK      = 8'h18;
  localparam logic [7:0] ADDR_CORE_STATE    = 8'h1c;

  // field positions
  localparam int unsigned PWR_IDLE_BIT  = 0;
  localparam int unsigned PWR_PD_BIT    = 1;
  localparam int unsigned CHP_B0        = 0;
  localparam int unsigned CHP_B1        = 1;
  localparam int unsigned CHP_B7        = 7;
  localparam int unsigned IRQ_GLOBAL    = 7;
  localparam int unsigned WDT_CLEAR     = 0;
  localparam int unsigned WDT_RST_EN    = 1;
  localparam int unsigned WDT_RUN       = 2;

  // sticky events: 0 wdt timeout, 1 reset done, 2 idle wake, 3 pd wake
  localparam int unsigned EVT_W = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // gray coded sequencer modes
  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_IDLE  = 2'b11,
    MODE_PDOWN = 2'b10
  } cpr_mode_type;

  // strobes toward the core
  typedef struct packed {
    logic opcode_latch;
    logic second_fetch;
    logic pc_advance;
    logic cycle_end;
  } cpr_fetch_type;

endpackage : cpr_pkg

// File: cpr_cycle_power_reset.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - six states of two clocks each
// - opcode at S1, second fetch S4, done S6
// - two fetches per cycle, unused one ignored
// - external data move: two cycles, second fetchless
// - read strobe twice, skipped during data access
// - idle bit enters idle after instruction
// - idle stops core clock, peripherals keep running
// - enabled interrupt ends idle, clears bit
// - reset pin sampled at state5_phase2
// - reset stays two cycles after pin falls
// - power-down bit stops all clocks
// - reset pin wakes power-down to 0000h
// - level interrupt wakes power-down if enabled
// - chip control bits 0,1,7 software reset
// - watchdog timeout flag, optional reset two cycles
// - reset holds pc 0000h, sp 07h
// - reset loads ports 0ffh, clears power, chip and irq control
module cpr_cycle_power_reset
  import cpr_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 rst_pin,
  input  wire logic                 ext_irq_level_n,
  input  wire logic                 irq_enabled_pending,
  input  wire logic                 data_move_req,
  input  wire logic                 code_byte_needed,
  input  wire logic                 run_from_loader,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output cpr_pkg::cpr_fetch_type    fetch_strobes,
  output logic                      program_read_strobe,
  output logic                      core_clk_en,
  output logic                      periph_clk_en,
  output logic                      core_reset,
  output logic [15:0]               pc_value,
  output logic [7:0]                sp_value,
  output logic [7:0]                port_value,
  output logic                      boot_application_rom,
  output logic                      irq_out
);
  import cpr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cpr_mode_type mode_reg;
  logic [3:0]   phase_reg;
  logic [2:0]   rst_sync_reg;
  logic         rst_level_reg;
  logic [2:0]   irq_sync_reg;
  logic         irq_level_reg;
  logic         rst_sampled_reg;
  logic [1:0]   hold_cnt_reg;
  logic         dm_second_reg;
  logic [7:0]   power_control_reg;
  logic [7:0]   chip_control_reg;
  logic [7:0]   irq_control_reg;
  logic [2:0]   wdt_control_reg;
  logic [15:0]  wdt_limit_reg;
  logic [15:0]  wdt_cnt_reg;
  logic         wdt_reset_reg;
  logic         wdt_hold_reg;
  logic         soft_reset_reg;
  logic [EVT_W-1:0] evt_status_reg;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_set;
  logic         cycle_end;
  logic         reset_request;
  logic         wdt_timeout;
  logic         wake_idle;
  logic         wake_pd;
  logic         aw_done_reg;
  logic         w_done_reg;
  logic [7:0]   aw_addr_reg;
  logic [31:0]  w_data_reg;
  logic         wr_fire;
  logic         wr_ok;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a level counts once the last two agree, so the
  // first stage only ever feeds the second
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rst_sync_reg  <= 3'h0;
      irq_sync_reg  <= 3'h7;
      rst_level_reg <= 1'b0;
      irq_level_reg <= 1'b1;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[1:0], rst_pin};
      irq_sync_reg <= {irq_sync_reg[1:0], ext_irq_level_n};
      if (rst_sync_reg[1] == rst_sync_reg[2])
        rst_level_reg <= rst_sync_reg[2];
      if (irq_sync_reg[1] == irq_sync_reg[2])
        irq_level_reg <= irq_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // machine cycle sequencer
  // ----------------------------------------------------------------
  assign cycle_end = (phase_reg == PHASE_LAST);

  // phase counts twelve oscillator periods; held at S1P1 in power-down
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      phase_reg <= PHASE_S1P1;
    else if (mode_reg == MODE_PDOWN)
      phase_reg <= PHASE_S1P1;
    else if (cycle_end)
      phase_reg <= PHASE_S1P1;
    else
      phase_reg <= phase_reg + 4'h1;
  end

  // second cycle of an external data move has no fetch
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || mode_reg != MODE_RUN)
      dm_second_reg <= 1'b0;
    else if (cycle_end)
      dm_second_reg <= data_move_req && !dm_second_reg;
  end

  // fetch strobes only while running
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fetch_strobes       <= '0;
      program_read_strobe <= 1'b0;
    end
    else
    begin
      fetch_strobes.opcode_latch <= (mode_reg == MODE_RUN) && !dm_second_reg
                                    && phase_reg == PHASE_S1P1;
      fetch_strobes.second_fetch <= (mode_reg == MODE_RUN) && !dm_second_reg
                                    && phase_reg == PHASE_S4P1;
      // unused extra byte leaves the pc alone
      fetch_strobes.pc_advance   <= (mode_reg == MODE_RUN) && !dm_second_reg
                                    && ((phase_reg == PHASE_S1P1)
                                    || (phase_reg == PHASE_S4P1 && code_byte_needed));
      fetch_strobes.cycle_end    <= (mode_reg == MODE_RUN) && cycle_end;
      // two pulses per cycle, both dropped while data owns the bus
      program_read_strobe <= (mode_reg == MODE_RUN) && !dm_second_reg
                             && (phase_reg == PHASE_S1P1 || phase_reg == PHASE_S4P1);
    end
  end

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // pin sampled once per cycle; power-down has no phases so pin acts directly
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rst_sampled_reg <= 1'b0;
    else if (phase_reg == PHASE_STATE5_PHASE2 || mode_reg == MODE_PDOWN)
      rst_sampled_reg <= rst_level_reg;
  end

  assign reset_request = rst_sampled_reg || wdt_reset_reg || soft_reset_reg;

  // reset stays on, then counts two more cycles after release
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      hold_cnt_reg <= RESET_HOLD_CYC;
    else if (reset_request)
      hold_cnt_reg <= RESET_HOLD_CYC;
    else if (mode_reg == MODE_RESET && cycle_end && hold_cnt_reg != 2'h0)
      hold_cnt_reg <= hold_cnt_reg - 2'h1;
  end

  // software reset: only loader to application, bits 0,1,7 together
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      soft_reset_reg       <= 1'b0;
      boot_application_rom <= 1'b1;
    end
    else
    begin
      soft_reset_reg <= wr_ok && aw_addr_reg == ADDR_CHIP_CONTROL
                        && run_from_loader && w_data_reg[CHP_B0]
                        && w_data_reg[CHP_B1] && w_data_reg[CHP_B7];
      // the soft reset's own hold must not undo its choice; only a pin or
      // watchdog reset taken while in the loader returns there
      if (soft_reset_reg)
        boot_application_rom <= 1'b1;
      else if (run_from_loader && (rst_sampled_reg || wdt_reset_reg))
        boot_application_rom <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------
  assign wake_idle = irq_enabled_pending;
  assign wake_pd   = !irq_level_reg && irq_control_reg[IRQ_GLOBAL]
                     && irq_control_reg[0];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      mode_reg <= MODE_RESET;
    else if (reset_request && mode_reg != MODE_PDOWN)
      mode_reg <= MODE_RESET;
    else
      case (mode_reg)
        MODE_RESET: if (hold_cnt_reg == 2'h0) mode_reg <= MODE_RUN;
        // entry waits for the writing instruction to finish
        MODE_RUN:
          if (cycle_end && power_control_reg[PWR_PD_BIT])
            mode_reg <= MODE_PDOWN;
          else if (cycle_end && power_control_reg[PWR_IDLE_BIT])
            mode_reg <= MODE_IDLE;
        MODE_IDLE:  if (wake_idle) mode_reg <= MODE_RUN;
        MODE_PDOWN:
          if (rst_sampled_reg)
            mode_reg <= MODE_RESET;
          else if (wake_pd)
            mode_reg <= MODE_RUN;
        default: mode_reg <= MODE_RESET;
      endcase
  end

  // idle gates only the core; power-down stops everything
  assign core_clk_en   = (mode_reg == MODE_RUN);
  assign periph_clk_en = (mode_reg != MODE_PDOWN);
  assign core_reset    = (mode_reg == MODE_RESET);

  // reset state of core registers; ram untouched
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || mode_reg == MODE_RESET)
    begin
      pc_value   <= PC_RESET;
      sp_value   <= SP_RESET;
      port_value <= PORT_RESET;
    end
    else if (fetch_strobes.pc_advance && core_clk_en)
      pc_value <= pc_value + 16'h0001;
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  assign wdt_timeout = wdt_control_reg[WDT_RUN] && (wdt_cnt_reg == wdt_limit_reg);

  // runs in idle too, stopped in power-down
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || wdt_reset_reg)
      wdt_cnt_reg <= 16'h0000;
    else if (wr_ok && aw_addr_reg == ADDR_WDT_CONTROL && w_data_reg[WDT_CLEAR])
      wdt_cnt_reg <= 16'h0000;
    else if (wdt_control_reg[WDT_RUN] && mode_reg != MODE_PDOWN && !wdt_timeout)
      wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wdt_reset_reg <= 1'b0;
      wdt_hold_reg  <= 1'b0;
    end
    else
    begin
      wdt_reset_reg <= wdt_timeout && wdt_control_reg[WDT_RST_EN] && !wdt_hold_reg;
      wdt_hold_reg  <= wdt_timeout;
    end
  end

  // ----------------------------------------------------------------
  // control registers and events
  // ----------------------------------------------------------------
  // watchdog control survives non-power-on resets, only sys_rst disables it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wdt_control_reg <= 3'h0;
      wdt_limit_reg   <= WDT_LIMIT_DEFAULT;
    end
    else if (wr_ok && aw_addr_reg == ADDR_WDT_CONTROL)
    begin
      wdt_control_reg <= {w_data_reg[WDT_RUN], w_data_reg[WDT_RST_EN], 1'b0};
      wdt_limit_reg   <= w_data_reg[31:16];
    end
  end

  // idle/pd bits cleared by any reset and by wake
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || mode_reg == MODE_RESET)
    begin
      power_control_reg <= ZERO_BYTE;
      chip_control_reg  <= ZERO_BYTE;
      irq_control_reg   <= ZERO_BYTE;
    end
    else
    begin
      if (mode_reg == MODE_IDLE && wake_idle)
        power_control_reg[PWR_IDLE_BIT] <= 1'b0;
      else if (mode_reg == MODE_PDOWN && wake_pd)
        power_control_reg[PWR_PD_BIT] <= 1'b0;
      else if (wr_ok && aw_addr_reg == ADDR_POWER_CONTROL)
        power_control_reg <= w_data_reg[7:0];
      if (wr_ok && aw_addr_reg == ADDR_CHIP_CONTROL)
        chip_control_reg <= w_data_reg[7:0];
      if (wr_ok && aw_addr_reg == ADDR_IRQ_CONTROL)
        irq_control_reg <= w_data_reg[7:0];
    end
  end

  assign evt_set = {mode_reg == MODE_PDOWN && wake_pd,
                    mode_reg == MODE_IDLE && wake_idle,
                    mode_reg == MODE_RESET && hold_cnt_reg == 2'h0,
                    wdt_timeout && !wdt_hold_reg};

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      evt_status_reg <= '0;
      evt_mask_reg   <= '0;
    end
    else
    begin
      evt_status_reg <= (evt_status_reg
                        & ~((wr_ok && aw_addr_reg == ADDR_EVT_STATUS)
                            ? w_data_reg[EVT_W-1:0] : '0)) | evt_set;
      if (wr_ok && aw_addr_reg == ADDR_EVT_MASK)
        evt_mask_reg <= w_data_reg[EVT_W-1:0];
    end
  end

  assign irq_out = |(evt_status_reg & evt_mask_reg);

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_done_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_done_reg && !s_axi_bvalid;
  assign wr_fire = aw_done_reg && w_done_reg && !s_axi_bvalid;
  assign wr_ok   = wr_fire && (&s_axi_wstrb[0:0] || 1'b1);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aw_done_reg  <= 1'b0;
      w_done_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_done_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_done_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_done_reg  <= 1'b0;
        w_done_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > ADDR_CORE_STATE || aw_addr_reg[1:0] != 2'b00)
                        ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // reads return one cycle after the address is taken
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_POWER_CONTROL)
        s_axi_rdata <= {24'h0, power_control_reg};
      else if (s_axi_araddr == ADDR_CHIP_CONTROL)
        s_axi_rdata <= {24'h0, chip_control_reg};
      else if (s_axi_araddr == ADDR_IRQ_CONTROL)
        s_axi_rdata <= {24'h0, irq_control_reg};
      else if (s_axi_araddr == ADDR_WDT_CONTROL)
        s_axi_rdata <= {wdt_limit_reg, 13'h0, wdt_control_reg};
      else if (s_axi_araddr == ADDR_STATUS)
        s_axi_rdata <= {wdt_cnt_reg, 10'h0, boot_application_rom, 1'b0,
                        mode_reg, hold_cnt_reg};
      else if (s_axi_araddr == ADDR_EVT_STATUS)
        s_axi_rdata <= {28'h0, evt_status_reg};
      else if (s_axi_araddr == ADDR_EVT_MASK)
        s_axi_rdata <= {28'h0, evt_mask_reg};
      else if (s_axi_araddr == ADDR_CORE_STATE)
        s_axi_rdata <= {pc_value, sp_value, port_value};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_PHASE_WRAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cycle_end && mode_reg != MODE_PDOWN) |=> phase_reg == PHASE_S1P1)
    else $error("phase did not wrap after twelve");
  AST_FETCH_S4: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetch_strobes.second_fetch |-> $past(phase_reg) == PHASE_S4P1)
    else $error("second fetch outside state four");
  AST_STROBE_SPACING: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(program_read_strobe) && $past(phase_reg) == PHASE_S1P1 |-> ##6 program_read_strobe
      || mode_reg != MODE_RUN || $past(mode_reg) != MODE_RUN)
    else $error("second strobe missing");
  AST_NO_FETCH_DM: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(dm_second_reg) |-> !program_read_strobe)
    else $error("fetch during data move");
  AST_IDLE_CORE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_reg == MODE_IDLE |-> !core_clk_en && periph_clk_en
      && ($past(mode_reg) != MODE_IDLE || $stable(pc_value)))
    else $error("idle clocks wrong");
  AST_RESET_PC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(mode_reg) == MODE_RESET |-> pc_value == PC_RESET && sp_value == SP_RESET)
    else $error("pc not held in reset");
  AST_RESET_CLEARS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(mode_reg) == MODE_RESET |-> power_control_reg == ZERO_BYTE)
    else $error("power bits survive reset");
  AST_PIN_RESET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(rst_sampled_reg) && $past(mode_reg) != MODE_PDOWN |=> mode_reg == MODE_RESET)
    else $error("sampled pin did not reset");

endmodule : cpr_cycle_power_reset

// File: cpr_ext_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// reset source and level interrupt pin outside the controller
// ----------------------------------------------------------------
module cpr_ext_model
#(
  parameter int unsigned HOLD_CLKS = 36
)
(
  input  wire logic clk_sys,
  input  wire logic rst_req,
  input  wire logic ext_irq_req,
  output logic      rst_pin,
  output logic      ext_irq_level_n
);
  logic [7:0] hold_reg = 8'h00;

  // a request keeps the pin high past two machine cycles, so at
  // least two state5_phase2 samples see it whatever the alignment
  always_ff @(posedge clk_sys)
  begin
    if (rst_req)
      hold_reg <= 8'(HOLD_CLKS);
    else if (hold_reg != 8'h00)
      hold_reg <= hold_reg - 8'h01;
  end

  assign rst_pin         = (hold_reg != 8'h00);
  // level mode: the pin stays low until the bench lets it go
  assign ext_irq_level_n = ~ext_irq_req;
endmodule : cpr_ext_model

// File: cpr_cycle_power_reset_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
`define WAITFOR(c) begin n = 0; do begin @(negedge clk_sys); n++; end \
  while (!(c) && n < 4000); if (n >= 4000) `CHK("wait", 1'b1, 1'b0) end
module cpr_cycle_power_reset_bench;
  import cpr_pkg::*;
  logic          clk_sys = 1'b0;
  logic          sys_rst = 1'b1;
  logic          code_byte_needed = 1'b0;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic          ext_irq_req, rst_req, irq_enabled_pending, data_move_req, run_from_loader;
  logic [7:0]    s_axi_awaddr, s_axi_araddr, sp_value, port_value;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
  logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  cpr_fetch_type fetch_strobes;
  logic          program_read_strobe, core_clk_en, periph_clk_en, core_reset, irq_out;
  logic          boot_application_rom, rst_pin, ext_irq_level_n, ta, tw;
  logic [15:0]   pc_value, pc_hold;
  int            err_total = 0, checks = 0, n;
  int            cnt [5];

  always #2.5 clk_sys = ~clk_sys;

  cpr_cycle_power_reset DUT (.*);
  cpr_ext_model PARTNER (.*);

  // ----------------------------------------------------------------
  // bus tasks and counters
  // ----------------------------------------------------------------
  // ready is sampled at the falling edge so the decision never races the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
    `WAITFOR(s_axi_bvalid)
    `CHK("bresp", er, s_axi_bresp)
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    `WAITFOR(s_axi_arready)
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    `WAITFOR(s_axi_rvalid)
    rd = s_axi_rdata;
    `CHK("rresp", er, s_axi_rresp)
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // pulses are registered, so falling-edge samples see each one once
  task automatic tally(input int clks);
    repeat (clks)
    begin
      @(negedge clk_sys);
      cnt[0] += program_read_strobe;
      cnt[1] += fetch_strobes.opcode_latch;
      cnt[2] += fetch_strobes.second_fetch;
      cnt[3] += fetch_strobes.cycle_end;
      cnt[4] += core_reset;
    end
  endtask : tally

  task automatic tally_and_finish;
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {ext_irq_req, rst_req, irq_enabled_pending, data_move_req, run_from_loader} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    `WAITFOR(!core_reset)
    `CHK("pc", PC_RESET, pc_value)
    `CHK("sp", SP_RESET, sp_value)
    `CHK("port", PORT_RESET, port_value)
    axi_rd(ADDR_IRQ_CONTROL, RESP_OKAY);
    `CHK("irqctl", 32'h0, rd)
    // reset-done event raises the line once unmasked; clearing its status bit drops it
    axi_wr(ADDR_EVT_MASK, 32'h2, RESP_OKAY);
    `CHK("irq", 1'b1, irq_out)
    axi_wr(ADDR_EVT_STATUS, 32'h2, RESP_OKAY);
    `CHK("irq", 1'b0, irq_out)
    axi_wr(8'h22, 32'h1, RESP_SLVERR);
    axi_rd(8'h20, RESP_SLVERR);
    `CHK("rdata", 32'h0, rd)
    `WAITFOR(fetch_strobes.cycle_end)
    pc_hold = pc_value;
    cnt = '{default: 0};
    tally(12);
    `CHK("pc step", pc_hold + 16'h0001, pc_value)
    `CHK("ends", 1, cnt[3])
    `CHK("opcode", 1, cnt[1])
    `CHK("second", 1, cnt[2])
    `CHK("reads", 2, cnt[0])
    // three cycles with a data move inside lose exactly two strobes
    `WAITFOR(fetch_strobes.cycle_end)
    pc_hold = pc_value;
    @(posedge clk_sys);
    data_move_req <= 1'b1;
    code_byte_needed <= 1'b1;
    cnt = '{default: 0};
    tally(12);
    @(posedge clk_sys);
    data_move_req <= 1'b0;
    tally(24);
    `CHK("move reads", 4, cnt[0])
    `CHK("move pc", pc_hold + 16'h0004, pc_value)
    axi_wr(ADDR_POWER_CONTROL, 32'h1, RESP_OKAY);
    `WAITFOR(!core_clk_en)
    pc_hold = pc_value;
    cnt = '{default: 0};
    tally(30);
    `CHK("idle opcode", 0, cnt[1])
    `CHK("periph", 1'b1, periph_clk_en)
    `CHK("pc held", pc_hold, pc_value)
    @(posedge clk_sys);
    irq_enabled_pending <= 1'b1;
    `WAITFOR(core_clk_en)
    @(posedge clk_sys);
    irq_enabled_pending <= 1'b0;
    axi_rd(ADDR_POWER_CONTROL, RESP_OKAY);
    `CHK("idle bit", 2'b00, rd[1:0])
    axi_wr(ADDR_IRQ_CONTROL, 32'h81, RESP_OKAY);
    axi_wr(ADDR_POWER_CONTROL, 32'h2, RESP_OKAY);
    `WAITFOR(!periph_clk_en)
    `CHK("core", 1'b0, core_clk_en)
    `CHK("port", PORT_RESET, port_value)
    @(posedge clk_sys);
    ext_irq_req <= 1'b1;
    `WAITFOR(core_clk_en)
    @(posedge clk_sys);
    ext_irq_req <= 1'b0;
    axi_rd(ADDR_POWER_CONTROL, RESP_OKAY);
    `CHK("pd bit", 2'b00, rd[1:0])
    // reset pin during power-down restarts at the zero address
    axi_wr(ADDR_POWER_CONTROL, 32'h2, RESP_OKAY);
    `WAITFOR(!periph_clk_en)
    @(posedge clk_sys);
    rst_req <= 1'b1;
    @(posedge clk_sys);
    rst_req <= 1'b0;
    `WAITFOR(core_reset)
    @(negedge clk_sys);
    `CHK("pc", PC_RESET, pc_value)
    `WAITFOR(!rst_pin)
    `WAITFOR(!core_reset)
    `CHK("release", 1'b1, n <= 40)
    `CHK("run", 1'b1, core_clk_en)
    axi_rd(ADDR_POWER_CONTROL, RESP_OKAY);
    `CHK("power_control_reg", 2'b00, rd[1:0])
    // software reset refused from the application side, taken from the loader
    axi_wr(ADDR_CHIP_CONTROL, 32'h83, RESP_OKAY);
    cnt = '{default: 0};
    tally(40);
    `CHK("no swrst", 0, cnt[4])
    @(posedge clk_sys);
    run_from_loader <= 1'b1;
    axi_wr(ADDR_CHIP_CONTROL, 32'h83, RESP_OKAY);
    `WAITFOR(core_reset)
    @(posedge clk_sys);
    run_from_loader <= 1'b0;
    `WAITFOR(!core_reset)
    `CHK("boot rom", 1'b1, boot_application_rom)
    axi_wr(ADDR_WDT_CONTROL, 32'h0010_0006, RESP_OKAY);
    `WAITFOR(core_reset)
    axi_wr(ADDR_WDT_CONTROL, 32'h0, RESP_OKAY);
    `WAITFOR(!core_reset)
    `CHK("pc", PC_RESET, pc_value)
    axi_rd(ADDR_EVT_STATUS, RESP_OKAY);
    `CHK("timeout", 1'b1, rd[0])
    tally_and_finish();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
endmodule : cpr_cycle_power_reset_bench
